/* shared/pcss_pkg.sv */
// constants and types for the socket status and power register bank
package pcss_pkg;
   // register indexes inside the socket register space
   localparam logic [7:0] IDX_IFACE_STATUS  = 8'h01;
   localparam logic [7:0] IDX_POWER_REQ     = 8'h02;
   localparam logic [7:0] IDX_GEN_IRQ       = 8'h03;
   localparam logic [7:0] IDX_STATUS_CHANGE = 8'h04;
   localparam logic [7:0] IDX_CHANGE_CFG    = 8'h05;
   localparam logic [7:0] IDX_GLOBAL        = 8'h1E;
   // memory window: socket registers start 800h above the base
   localparam logic [11:0] MEM_REG_OFFSET   = 12'h800;
   localparam logic [3:0]  MEM_REG_PAGE     = 4'h8;
   // io port select: index or data byte of the pair
   localparam logic IO_PORT_INDEX = 1'b0;
   localparam logic IO_PORT_DATA  = 1'b1;
   // reset values
   localparam logic [5:0] PIN_RST           = 6'h3F;
   localparam logic [7:0] POWER_REQ_RST     = 8'h00;
   localparam logic [3:0] STATUS_CHANGE_RST = 4'h0;
   localparam logic [7:0] BYTE_ZERO         = 8'h00;
   // writable bits of the global control register
   localparam logic [7:0] GLOBAL_WR_MASK    = 8'h0E;
   // requested supply voltage
   typedef enum logic [1:0] {
      PCSS_VCC_OFF  = 2'b00,
      PCSS_VCC_RSVD = 2'b01,
      PCSS_VCC_5V0  = 2'b10,
      PCSS_VCC_3V3  = 2'b11
   } pcss_vcc_t;
   // requested programming voltage
   typedef enum logic [1:0] {
      PCSS_VPP_OFF  = 2'b00,
      PCSS_VPP_5V0  = 2'b01,
      PCSS_VPP_12V0 = 2'b10,
      PCSS_VPP_RSVD = 2'b11
   } pcss_vpp_t;
   // socket pin levels, in interface status bit order 5..0
   typedef struct packed {
      logic ready;
      logic wp;
      logic cd2_n;
      logic cd1_n;
      logic bvd2;
      logic bvd1;
   } pcss_pins_t;
   // power request register layout
   typedef struct packed {
      logic       oe;
      logic [2:0] rsvd;
      pcss_vcc_t  vcc;
      pcss_vpp_t  vpp;
   } pcss_power_t;
   // status change bits 3..0
   typedef struct packed {
      logic detect;
      logic ready;
      logic batt_warn;
      logic batt_dead;
   } pcss_change_t;
   // global control bits
   typedef struct packed {
      logic [3:0] rsvd_hi;
      logic       ireq_level;
      logic       explicit_ack;
      logic       csc_level;
      logic       rsvd_lo;
   } pcss_global_t;
   // general interrupt control bits
   typedef struct packed {
      logic       ring_en;
      logic       rsvd6;
      logic       io_card;
      logic [4:0] other;
   } pcss_genirq_t;
endpackage

/* shared/pcss_pin_if.sv */
// synchronised socket pin levels passed from the synchroniser to the bank
`timescale 1ns/100ps
interface pcss_pin_if;
   pcss_pkg::pcss_pins_t levels;
   modport src (output levels);
   modport dst (input  levels);
endinterface

/* logic/pcss_pin_sync.sv */
// two-flop synchroniser for the socket pins
`timescale 1ns/100ps
module pcss_pin_sync (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire pcss_pkg::pcss_pins_t pins_raw,
   pcss_pin_if.src                  pins
);
   typedef struct packed {
      pcss_pkg::pcss_pins_t stage1;
      pcss_pkg::pcss_pins_t stage2;
   } pcss_sync_t;

   pcss_sync_t st_reg;
   pcss_sync_t st_next;

   // first stage feeds only the second stage
   always_comb begin
      st_next        = st_reg;
      st_next.stage1 = pins_raw;
      st_next.stage2 = st_reg.stage1;
   end

   // pins idle high: no card, card ready, batteries good
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg.stage1 <= pcss_pkg::PIN_RST;
         st_reg.stage2 <= pcss_pkg::PIN_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pins.levels = st_reg.stage2;
endmodule

/* logic/pcss_socket_regs.sv */
// socket status, power request and status change register bank
`timescale 1ns/100ps
module pcss_socket_regs (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire pcss_pkg::pcss_pins_t pins_raw,
   input  wire logic                 iface_powered,
   input  wire logic [1:0]           cb_detect_event,
   input  wire logic                 cb_power_wr,
   input  wire pcss_pkg::pcss_vcc_t  cb_vcc_req,
   input  wire pcss_pkg::pcss_vpp_t  cb_vpp_req,
   input  wire logic                 window_wp,
   input  wire logic                 card_wr_req,
   input  wire logic                 io_sel,
   input  wire logic                 io_wr,
   input  wire logic                 io_rd,
   input  wire logic [11:0]          mem_addr,
   input  wire logic                 mem_wr,
   input  wire logic                 mem_rd,
   input  wire logic [7:0]           wdata,
   output logic [7:0]                rdata,
   output logic                      rd_valid,
   output logic                      socket_drive_oe,
   output pcss_pkg::pcss_vcc_t       vcc_req,
   output pcss_pkg::pcss_vpp_t       vpp_req,
   output logic                      card_wr_go,
   output logic                      csc_irq
);
   // whole state of the bank
   typedef struct packed {
      logic [7:0]             index;
      pcss_pkg::pcss_power_t  power;
      pcss_pkg::pcss_change_t change;
      logic [7:0]             change_cfg;
      pcss_pkg::pcss_global_t glob;
      pcss_pkg::pcss_genirq_t genirq;
      pcss_pkg::pcss_pins_t   pins_prev;
      logic [1:0]             cb_prev;
      pcss_pkg::pcss_vcc_t    vcc_out;
      pcss_pkg::pcss_vpp_t    vpp_out;
      logic [7:0]             rdata;
      logic                   rd_valid;
      logic                   card_wr_go;
      logic                   irq;
   } pcss_state_t;

   pcss_state_t st_reg;
   pcss_state_t st_next;

   // window offset split into register page and register index
   typedef struct packed {
      logic [3:0] page;
      logic [7:0] index;
   } pcss_win_addr_t;

   // width of the change latch, and the idle level of the cardbus event bits
   localparam int         CHANGE_BITS   = $bits(pcss_pkg::pcss_change_t);
   localparam logic [1:0] CB_EVENT_IDLE = 2'h0;

   pcss_pin_if pin_bus ();

   // pins from the card come through two flops
   pcss_pin_sync u_sync (
      .clk      (clk),
      .rst      (rst),
      .pins_raw (pins_raw),
      .pins     (pin_bus.src)
   );

   pcss_pkg::pcss_pins_t   pins_now;
   logic                   acc_wr;
   logic                   acc_rd;
   logic [7:0]             acc_idx;
   logic                   io_card;
   logic [7:0]             status_byte;
   pcss_pkg::pcss_change_t change_enable;
   pcss_pkg::pcss_change_t change_visible;
   pcss_pkg::pcss_change_t change_set;
   pcss_pkg::pcss_change_t change_clr;
   logic                   warn_now;
   logic                   warn_prev;
   pcss_win_addr_t         win_addr;
   logic                   wr_power;
   logic                   wr_genirq;
   logic                   wr_cfg;
   logic                   wr_glob;
   logic                   wr_ack;
   logic                   rd_ack;
   logic                   rd_index;
   logic                   rd_unmapped;
   logic [7:0]             read_byte;
   pcss_pkg::pcss_power_t  power_wr;
   pcss_pkg::pcss_change_t io_mask;
   wire  [CHANGE_BITS-1:0] change_hold;

   assign pins_now = pin_bus.levels;
   assign io_card  = st_reg.genirq.io_card;
   assign win_addr = mem_addr;

   // enable bits line up with the change bits
   assign change_enable = st_reg.change_cfg[3:0];

   // access decode: io pair first, then the memory window
   always_comb begin
      acc_wr  = 1'b0;
      acc_rd  = 1'b0;
      acc_idx = st_reg.index;
      if ((io_wr || io_rd) && io_sel == pcss_pkg::IO_PORT_DATA) begin
         acc_wr = io_wr;
         acc_rd = io_rd;
      end else if (io_wr || io_rd) begin
         acc_wr = 1'b0;
         acc_rd = 1'b0;
      end else if ((mem_wr || mem_rd) && win_addr.page == pcss_pkg::MEM_REG_PAGE) begin
         acc_wr  = mem_wr;
         acc_rd  = mem_rd;
         acc_idx = win_addr.index;
      end else begin
         acc_wr = 1'b0;
         acc_rd = 1'b0;
      end
   end

   // one write strobe per writable register; status and unknown indexes take none
   always_comb begin
      wr_power  = 1'b0;
      wr_genirq = 1'b0;
      wr_cfg    = 1'b0;
      wr_glob   = 1'b0;
      if (acc_wr && acc_idx == pcss_pkg::IDX_POWER_REQ) begin
         wr_power = 1'b1;
      end else if (acc_wr && acc_idx == pcss_pkg::IDX_GEN_IRQ) begin
         wr_genirq = 1'b1;
      end else if (acc_wr && acc_idx == pcss_pkg::IDX_CHANGE_CFG) begin
         wr_cfg = 1'b1;
      end else if (acc_wr && acc_idx == pcss_pkg::IDX_GLOBAL) begin
         wr_glob = 1'b1;
      end
   end

   // acknowledge strobes: explicit write of ones when explicit_ack is set, otherwise any read of the change register
   assign wr_ack = acc_wr & (acc_idx == pcss_pkg::IDX_STATUS_CHANGE) & st_reg.glob.explicit_ack;
   assign rd_ack = acc_rd & (acc_idx == pcss_pkg::IDX_STATUS_CHANGE) & ~st_reg.glob.explicit_ack;

   // reads that no register answers: the index byte, or an offset outside the window
   assign rd_index    = io_rd & (io_sel == pcss_pkg::IO_PORT_INDEX);
   assign rd_unmapped = mem_rd & ~io_rd & ~io_wr & (win_addr.page != pcss_pkg::MEM_REG_PAGE);

   // live interface status byte
   always_comb begin
      status_byte = {1'b0, iface_powered,
                     pins_now.ready,
                     pins_now.wp,
                     pins_now.cd2_n,
                     pins_now.cd1_n,
                     pins_now.bvd2,
                     pins_now.bvd1};
   end

   // io cards never report ready or battery warning changes
   always_comb begin
      io_mask           = pcss_pkg::STATUS_CHANGE_RST;
      io_mask.ready     = io_card;
      io_mask.batt_warn = io_card;
   end

   // change bits as software sees them
   always_comb begin
      change_visible = st_reg.change & change_enable & ~io_mask;
   end

   // warning: first battery line good, second low
   assign warn_now  = ~io_card & pins_now.bvd1 & ~pins_now.bvd2;
   assign warn_prev = st_reg.pins_prev.bvd1 & ~st_reg.pins_prev.bvd2;

   // event detection, gated by the enable of each source
   always_comb begin
      change_set        = pcss_pkg::STATUS_CHANGE_RST;
      change_set.detect = (pins_now.cd1_n ^ st_reg.pins_prev.cd1_n)
                        | (pins_now.cd2_n ^ st_reg.pins_prev.cd2_n)
                        | (|(cb_detect_event ^ st_reg.cb_prev));
      change_set.ready  = ~io_card & pins_now.ready
                        & ~st_reg.pins_prev.ready;
      change_set.batt_warn = warn_now & ~warn_prev;
      // dead line or status-change line falling low
      change_set.batt_dead = ~pins_now.bvd1 & st_reg.pins_prev.bvd1;
      change_set = change_set & change_enable;
   end

   // clears: by explicit write of ones, or by reading the register
   always_comb begin
      change_clr = pcss_pkg::STATUS_CHANGE_RST;
      if (wr_ack) begin
         change_clr = wdata[CHANGE_BITS-1:0];
      end else if (rd_ack) begin
         change_clr = ~pcss_pkg::STATUS_CHANGE_RST;
      end
      // memory card dead bit drops once the battery recovers
      if (!io_card && pins_now.bvd1) begin
         change_clr.batt_dead = 1'b1;
      end
   end

   // each change bit stays latched until cleared; a new event wins over a clear
   for (genvar b = 0; b < CHANGE_BITS; b++) begin : g_latch
      assign change_hold[b] = (st_reg.change[b] & ~change_clr[b]) | change_set[b];
   end

   // power request as written: reserved bits forced to zero
   always_comb begin
      power_wr      = wdata;
      power_wr.rsvd = 3'h0;
   end

   // read data of the register picked by the access index
   always_comb begin
      read_byte = pcss_pkg::BYTE_ZERO;
      if (acc_idx == pcss_pkg::IDX_IFACE_STATUS) begin
         read_byte = status_byte;
      end else if (acc_idx == pcss_pkg::IDX_POWER_REQ) begin
         read_byte = st_reg.power;
      end else if (acc_idx == pcss_pkg::IDX_GEN_IRQ) begin
         read_byte = st_reg.genirq;
      end else if (acc_idx == pcss_pkg::IDX_STATUS_CHANGE) begin
         read_byte = {4'h0, change_visible};
      end else if (acc_idx == pcss_pkg::IDX_CHANGE_CFG) begin
         read_byte = st_reg.change_cfg;
      end else if (acc_idx == pcss_pkg::IDX_GLOBAL) begin
         read_byte = st_reg.glob;
      end else begin
         read_byte = pcss_pkg::BYTE_ZERO; // unknown index reads as zero
      end
   end

   // next state
   always_comb begin
      st_next            = st_reg;
      st_next.rd_valid   = 1'b0;
      st_next.pins_prev  = pins_now;
      st_next.cb_prev    = cb_detect_event;

      // index byte of the io pair
      if (io_wr && io_sel == pcss_pkg::IO_PORT_INDEX) begin
         st_next.index = wdata;
      end

      // register writes
      if (wr_power) begin
         st_next.power   = power_wr;
         st_next.vcc_out = power_wr.vcc;
         st_next.vpp_out = power_wr.vpp;
      end
      if (wr_genirq) begin
         st_next.genirq = wdata;
      end
      if (wr_cfg) begin
         st_next.change_cfg = wdata;
      end
      if (wr_glob) begin
         st_next.glob = wdata & pcss_pkg::GLOBAL_WR_MASK;
      end

      // cardbus side may program the supply instead
      if (cb_power_wr) begin
         st_next.vcc_out   = cb_vcc_req;
         st_next.vpp_out   = cb_vpp_req;
         st_next.power.vcc = cb_vcc_req;
         st_next.power.vpp = cb_vpp_req;
      end

      // latched bits, a new event wins over a clear
      st_next.change = change_hold;

      // register reads, answered next cycle
      if (acc_rd) begin
         st_next.rd_valid = 1'b1;
         st_next.rdata    = read_byte;
      end else if (rd_index) begin
         st_next.rd_valid = 1'b1;
         st_next.rdata    = st_reg.index;
      end else if (rd_unmapped) begin
         st_next.rd_valid = 1'b1; // unmapped window reads as zero
         st_next.rdata    = pcss_pkg::BYTE_ZERO;
      end

      // card memory write passes unless the window protects it
      st_next.card_wr_go = card_wr_req & ~window_wp;

      // interrupt from any latched enabled source, except ready and battery warning on io cards
      st_next.irq = |(st_next.change & change_enable & ~io_mask);
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg.index      <= pcss_pkg::BYTE_ZERO;
         st_reg.power      <= pcss_pkg::POWER_REQ_RST;
         st_reg.change     <= pcss_pkg::STATUS_CHANGE_RST;
         st_reg.change_cfg <= pcss_pkg::BYTE_ZERO;
         st_reg.glob       <= pcss_pkg::BYTE_ZERO;
         st_reg.genirq     <= pcss_pkg::BYTE_ZERO;
         st_reg.pins_prev  <= pcss_pkg::PIN_RST;
         st_reg.cb_prev    <= CB_EVENT_IDLE;
         st_reg.vcc_out    <= pcss_pkg::PCSS_VCC_OFF;
         st_reg.vpp_out    <= pcss_pkg::PCSS_VPP_OFF;
         st_reg.rdata      <= pcss_pkg::BYTE_ZERO;
         st_reg.rd_valid   <= 1'b0;
         st_reg.card_wr_go <= 1'b0;
         st_reg.irq        <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state flops
   assign rdata           = st_reg.rdata;
   assign rd_valid        = st_reg.rd_valid;
   assign socket_drive_oe = st_reg.power.oe;
   assign vcc_req         = st_reg.vcc_out;
   assign vpp_req         = st_reg.vpp_out;
   assign card_wr_go      = st_reg.card_wr_go;
   assign csc_irq         = st_reg.irq;
endmodule

/* verif/pcss_card_model.sv */
// behavioural pc card seen from the socket pins
`timescale 1ns/100ps
module pcss_card_model (
   input  wire logic           card_in,
   input  wire logic           ready_lvl,
   input  wire logic           wp_lvl,
   input  wire logic [1:0]     bvd_lvl,
   output pcss_pkg::pcss_pins_t pins_raw
);
   // an empty socket lets every line float high on its pull-up
   assign pins_raw = card_in ? {ready_lvl, wp_lvl, 2'h0, bvd_lvl} : 6'h3F;
endmodule

/* verif/pcss_socket_regs_sva.sv */
// port assertions for the socket register bank
`timescale 1ns/100ps
module pcss_socket_regs_sva (
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                iface_powered,
   input wire logic                cb_power_wr,
   input wire pcss_pkg::pcss_vcc_t cb_vcc_req,
   input wire pcss_pkg::pcss_vpp_t cb_vpp_req,
   input wire logic                window_wp,
   input wire logic                card_wr_req,
   input wire logic                io_wr,
   input wire logic                io_rd,
   input wire logic [11:0]         mem_addr,
   input wire logic                mem_wr,
   input wire logic                mem_rd,
   input wire logic [7:0]          wdata,
   input wire logic [7:0]          rdata,
   input wire logic                rd_valid,
   input wire logic                socket_drive_oe,
   input wire pcss_pkg::pcss_vcc_t vcc_req,
   input wire pcss_pkg::pcss_vpp_t vpp_req,
   input wire logic                card_wr_go
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // memory accesses that no io strobe overrides
   sequence mem_read_at(logic [11:0] a);
      mem_rd && !io_rd && !io_wr && mem_addr == a;
   endsequence
   sequence mem_read_off;
      mem_rd && !io_rd && !io_wr && mem_addr[11:8] != 4'h8;
   endsequence
   sequence power_write;
      mem_wr && !io_wr && !io_rd && !cb_power_wr && mem_addr == 12'h802;
   endsequence
   read_answer_a: assert property ((io_rd || (mem_rd && !io_wr)) |=> rd_valid) else $error("read not answered");
   answer_cause_a: assert property (rd_valid |-> $past(io_rd || mem_rd)) else $error("answer without read");
   status_top_a: assert property (mem_read_at(12'h801) |=> rdata[7:6] == {1'b0, $past(iface_powered)})
      else $error("status bits 7:6 wrong");
   power_rsvd_a: assert property (mem_read_at(12'h802) |=> rdata[6:4] == 3'h0) else $error("power reserved set");
   change_rsvd_a: assert property (mem_read_at(12'h804) |=> rdata[7:4] == 4'h0) else $error("change upper set");
   unmapped_zero_a: assert property (mem_read_off |=> rdata == 8'h00) else $error("unmapped read nonzero");
   power_write_a: assert property (power_write |=> socket_drive_oe == $past(wdata[7])
      && {vcc_req, vpp_req} == $past(wdata[3:0])) else $error("power request not taken");
   cb_power_a: assert property (cb_power_wr |=> vcc_req == $past(cb_vcc_req) && vpp_req == $past(cb_vpp_req))
      else $error("cardbus supply not taken");
   wp_gate_a: assert property (card_wr_req |=> card_wr_go == !$past(window_wp)) else $error("write gate wrong");
   no_spurious_go_a: assert property (!card_wr_req |=> !card_wr_go) else $error("write without request");
endmodule
bind pcss_socket_regs pcss_socket_regs_sva pcss_socket_regs_sva_i (.clk, .rst, .iface_powered, .cb_power_wr,
   .cb_vcc_req, .cb_vpp_req, .window_wp, .card_wr_req, .io_wr, .io_rd, .mem_addr, .mem_wr, .mem_rd, .wdata,
   .rdata, .rd_valid, .socket_drive_oe, .vcc_req, .vpp_req, .card_wr_go);

/* verif/test_pc_card_socket_status_power_regs.sv */
// self-checking bench for the socket status and power register bank
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_pc_card_socket_status_power_regs;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 iface_powered = 1'b0;
   logic [1:0]           cb_detect_event = 2'h0;
   logic                 cb_power_wr = 1'b0;
   pcss_pkg::pcss_vcc_t  cb_vcc_req = pcss_pkg::PCSS_VCC_OFF;
   pcss_pkg::pcss_vpp_t  cb_vpp_req = pcss_pkg::PCSS_VPP_OFF;
   logic                 window_wp = 1'b0, card_wr_req = 1'b0, io_sel = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
   logic                 mem_wr = 1'b0, mem_rd = 1'b0, card_in = 1'b0, ready_lvl = 1'b0, wp_lvl = 1'b0;
   logic [1:0]           bvd_lvl = 2'h3;
   logic [11:0]          mem_addr = 12'h000;
   logic [7:0]           wdata = 8'h00, rdata, q;
   logic                 rd_valid, socket_drive_oe, card_wr_go, csc_irq;
   pcss_pkg::pcss_vcc_t  vcc_req;
   pcss_pkg::pcss_vpp_t  vpp_req;
   pcss_pkg::pcss_pins_t pins_raw;
   int                   failures = 0, total_checks = 0, i;
   // clock and the two parties
   always #4 clk = ~clk;
   pcss_card_model pcss_card_model_i (.card_in, .ready_lvl, .wp_lvl, .bvd_lvl, .pins_raw);
   pcss_socket_regs pcss_socket_regs_i (.clk, .rst, .pins_raw, .iface_powered, .cb_detect_event, .cb_power_wr,
      .cb_vcc_req, .cb_vpp_req, .window_wp, .card_wr_req, .io_sel, .io_wr, .io_rd, .mem_addr, .mem_wr, .mem_rd,
      .wdata, .rdata, .rd_valid, .socket_drive_oe, .vcc_req, .vpp_req, .card_wr_go, .csc_irq);
   // one register access; io uses the index then the data port
   task acc(input logic mem, input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
      @(negedge clk);
      if (!mem) begin
         io_sel = 1'b0; io_wr = 1'b1; wdata = a[7:0];
         @(negedge clk);
         io_sel = 1'b1; io_wr = wr; io_rd = !wr; wdata = d;
      end else begin
         mem_addr = a; mem_wr = wr; mem_rd = !wr; wdata = d;
      end
      @(negedge clk);
      io_wr = 1'b0; io_rd = 1'b0; mem_wr = 1'b0; mem_rd = 1'b0;
      r = rdata;
      if (!wr) `CHK("rd_valid", 1'b1, rd_valid)
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      acc(1'b1, 1'b1, a, d, q);
   endtask
   task rd_chk(input logic [11:0] a, input logic [7:0] e);
      acc(1'b1, 1'b0, a, 8'h00, q);
      `CHK($sformatf("rdata %h", a), e, q)
   endtask
   task cycles(input int n);
      repeat (n) @(negedge clk);
   endtask
   task give_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // watchdog against a hung sequence
   initial begin
      #100000;
      failures++;
      give_verdict;
   end
   // main sequence
   initial begin
      cycles(6); rst = 1'b0; cycles(3);
      acc(1'b0, 1'b0, 12'h801, 8'h00, q); `CHK("io status", 8'h3F, q)
      rd_chk(12'h801, 8'h3F); rd_chk(12'h802, 8'h00);
      rd_chk(12'h804, 8'h00); rd_chk(12'h123, 8'h00);
      acc(1'b0, 1'b1, 12'h802, 8'h8A, q); rd_chk(12'h802, 8'h8A); rd_chk(12'h8FF, 8'h00);
      `CHK("io vcc", 2'h2, vcc_req)
      card_in = 1'b1; ready_lvl = 1'b1; iface_powered = 1'b1; cycles(4);
      rd_chk(12'h801, 8'h63);
      ready_lvl = 1'b0; wp_lvl = 1'b1; bvd_lvl = 2'h2; cycles(4);
      rd_chk(12'h801, 8'h52);
      bvd_lvl = 2'h3;
      for (i = 0; i < 16; i++) begin
         wr(12'h802, {4'hF, i[3:0]});
         rd_chk(12'h802, {4'h8, i[3:0]});
         `CHK("oe", 1'b1, socket_drive_oe)
         `CHK("vcc", i[3:2], vcc_req)
         `CHK("vpp", i[1:0], vpp_req)
      end
      wr(12'h802, 8'h00); `CHK("oe", 1'b0, socket_drive_oe)
      @(negedge clk); cb_vcc_req = pcss_pkg::PCSS_VCC_3V3; cb_vpp_req = pcss_pkg::PCSS_VPP_12V0; cb_power_wr = 1'b1;
      @(negedge clk); cb_power_wr = 1'b0;
      `CHK("cb vcc", 2'h3, vcc_req)
      `CHK("cb vpp", 2'h2, vpp_req)
      for (i = 0; i < 2; i++) begin
         @(negedge clk); window_wp = i[0]; card_wr_req = 1'b1;
         @(negedge clk); card_wr_req = 1'b0;
         `CHK("card_wr_go", !i[0], card_wr_go)
      end
      card_in = 1'b0; cycles(5); rd_chk(12'h804, 8'h00);
      wr(12'h805, 8'h0F); card_in = 1'b1; cycles(5);
      `CHK("irq", 1'b1, csc_irq)
      rd_chk(12'h804, 8'h08); rd_chk(12'h804, 8'h00);
      `CHK("irq", 1'b0, csc_irq)
      cb_detect_event = 2'h2; cycles(4); rd_chk(12'h804, 8'h08);
      ready_lvl = 1'b1; cycles(5); ready_lvl = 1'b0; cycles(5);
      rd_chk(12'h804, 8'h04);
      wr(12'h81E, 8'h04); bvd_lvl = 2'h1; cycles(5);
      rd_chk(12'h804, 8'h02); rd_chk(12'h804, 8'h02);
      wr(12'h805, 8'h0D); rd_chk(12'h805, 8'h0D); rd_chk(12'h804, 8'h00);
      wr(12'h805, 8'h0F); rd_chk(12'h804, 8'h02); rd_chk(12'h81E, 8'h04);
      wr(12'h804, 8'h05); rd_chk(12'h804, 8'h02);
      wr(12'h804, 8'h02); rd_chk(12'h804, 8'h00);
      bvd_lvl = 2'h2; cycles(5); rd_chk(12'h804, 8'h01);
      bvd_lvl = 2'h3; cycles(5); rd_chk(12'h804, 8'h00);
      wr(12'h803, 8'h20); ready_lvl = 1'b1; bvd_lvl = 2'h2; cycles(5); bvd_lvl = 2'h3; cycles(5);
      rd_chk(12'h804, 8'h01);
      wr(12'h804, 8'h01); cycles(2);
      `CHK("irq", 1'b0, csc_irq)
      give_verdict;
   end
endmodule
